// File: logic/packet_holder.sv
/*
 * One-entry store for the current 256-bit fetch packet; read data is
 * registered. Assumes the writer loads only between fetch packets.
 */
`timescale 1ns/10ps
`include "fetch_dispatch_map.svh"

module packet_holder (
    input  wire logic   i_clk,
    input  wire logic   i_srst,
    packet_hold_if.holder hold
);
    fetch_dispatch_pkg::packet_t mem_q;

    // Capture a whole fetch packet on load
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            mem_q <= '0;
        end else if (hold.load) begin
            mem_q <= hold.wr_packet;
        end
    end

    assign hold.rd_packet = mem_q;
endmodule

// File: logic/vliw_fetch_packet_dispatcher.sv
/*
 * Fetch and dispatch front end of an eight-unit VLIW core: takes fetch
 * packets, splits them into execute packets by the chain bit, issues one
 * execute packet per clock to eight unit slots.
 * Assumes program memory answers a request with one valid pulse and that
 * code never lets an execute packet cross a fetch packet.
 */
`timescale 1ns/10ps
`include "fetch_dispatch_map.svh"

module vliw_fetch_packet_dispatcher #(
    parameter int SLOTS  = `FD_SLOTS,
    parameter int INSN_W = `FD_INSN_W
) (
    input  wire logic                          i_clk,
    input  wire logic                          i_srst,
    input  wire logic                          i_run,
    input  wire logic [31:0]                   i_start_addr,
    input  wire logic                          i_pm_valid,
    input  wire logic [`FD_PACKET_W-1:0]       i_pm_packet,
    output logic                               o_pm_req,
    output logic [31:0]                        o_pm_addr,
    output logic [SLOTS-1:0]                   o_unit_valid,
    output logic [SLOTS*INSN_W-1:0]            o_unit_insn,
    output logic [SLOTS*`FD_SIZE_W-1:0]        o_unit_size,
    output logic [SLOTS-1:0]                   o_unit_side_b,
    output logic                               o_packet_last
);
    // Elaboration-time check of what the slot logic can serve
    if (SLOTS != `FD_SLOTS || INSN_W != `FD_INSN_W
        || SLOTS * INSN_W != `FD_PACKET_W) begin : g_bad_params
        $error("Dispatcher supports only eight 32-bit slots");
    end

    localparam int PTR_W = $clog2(SLOTS) + 1;

    fetch_dispatch_pkg::disp_state_e state_q;
    logic [PTR_W-1:0]                ptr_q;
    fetch_dispatch_pkg::slot_mask_t  sel;
    logic [PTR_W-1:0]                next_ptr;
    logic                            pkt_done;
    packet_hold_if                   hold ();

    // Instruction of a slot out of the held packet
    function automatic fetch_dispatch_pkg::insn_t slot_insn(
        input fetch_dispatch_pkg::packet_t pkt, input int idx);
        slot_insn = pkt[idx*INSN_W +: INSN_W];
    endfunction

    // Target unit of an instruction, 0..7
    function automatic logic [`FD_UNIT_W-1:0] unit_of(
        input fetch_dispatch_pkg::insn_t insn);
        unit_of = insn[`FD_UNIT_LSB +: `FD_UNIT_W];
    endfunction

    packet_holder u_holder (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .hold   (hold.holder)
    );

    assign hold.load      = (state_q == fetch_dispatch_pkg::ST_WAIT) && i_pm_valid;
    assign hold.wr_packet = i_pm_packet;

    // Pick the chained run starting at ptr_q
    always_comb begin
        logic chain;
        chain    = 1'b1;
        sel      = '0;
        next_ptr = PTR_W'(SLOTS);
        for (int i = 0; i < SLOTS; i++) begin
            if (chain && i >= int'(ptr_q)) begin
                sel[i] = 1'b1;
                if (!hold.rd_packet[i*INSN_W + `FD_CHAIN_BIT]) begin
                    chain    = 1'b0;
                    next_ptr = PTR_W'(i + 1);
                end
            end
        end
        // The loop never reaches past the last slot
        pkt_done = (next_ptr >= PTR_W'(SLOTS));
    end

    // Sequencer: fetch, wait for packet, issue execute packets
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_q <= fetch_dispatch_pkg::ST_FETCH;
            ptr_q   <= '0;
        end else begin
            case (state_q)
                fetch_dispatch_pkg::ST_FETCH: begin
                    if (i_run) begin
                        state_q <= fetch_dispatch_pkg::ST_WAIT;
                    end
                end
                fetch_dispatch_pkg::ST_WAIT: begin
                    if (i_pm_valid) begin
                        state_q <= fetch_dispatch_pkg::ST_ISSUE;
                        ptr_q   <= '0;
                    end
                end
                fetch_dispatch_pkg::ST_ISSUE: begin
                    ptr_q <= next_ptr;
                    if (pkt_done) begin
                        state_q <= fetch_dispatch_pkg::ST_FETCH;
                    end
                end
                default: begin
                    state_q <= fetch_dispatch_pkg::ST_FETCH;
                end
            endcase
        end
    end

    // Fetch request pulse and running fetch address
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_pm_req  <= 1'b0;
            o_pm_addr <= `FD_ADDR_RST;
        end else begin
            o_pm_req <= (state_q == fetch_dispatch_pkg::ST_FETCH) && i_run;
            if (state_q == fetch_dispatch_pkg::ST_FETCH && !i_run) begin
                o_pm_addr <= i_start_addr;
            end else if (state_q == fetch_dispatch_pkg::ST_ISSUE && pkt_done) begin
                o_pm_addr <= o_pm_addr + 32'(`FD_PACKET_W / 8);  // Next 32-byte packet
            end
        end
    end

    // Route the selected instructions to their units
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_unit_valid  <= '0;
            o_unit_insn   <= '0;
            o_unit_size   <= '0;
            o_unit_side_b <= '0;
            o_packet_last <= 1'b0;
        end else begin
            o_unit_valid  <= '0;
            o_packet_last <= 1'b0;
            if (state_q == fetch_dispatch_pkg::ST_ISSUE) begin
                o_packet_last <= pkt_done;
                for (int i = 0; i < SLOTS; i++) begin
                    fetch_dispatch_pkg::insn_t ins;
                    logic [`FD_UNIT_W-1:0]     u;
                    ins = slot_insn(hold.rd_packet, i);
                    u   = unit_of(ins);
                    if (sel[i]) begin
                        o_unit_valid[u] <= 1'b1;
                        o_unit_insn[u*INSN_W +: INSN_W] <= ins;
                        // Upper four units form side B
                        o_unit_side_b[u] <= (int'(u) >= `FD_SIDE_UNITS);
                        if (ins[`FD_LS_FLAG_BIT]) begin
                            o_unit_size[u*`FD_SIZE_W +: `FD_SIZE_W]
                                <= ins[`FD_SIZE_LSB +: `FD_SIZE_W];
                        end else begin
                            o_unit_size[u*`FD_SIZE_W +: `FD_SIZE_W] <= `FD_SIZE_WORD;
                        end
                    end
                end
            end
        end
    end
endmodule

// File: shared/fetch_dispatch_map.svh
/*
 * Constants of the fetch packet dispatcher: widths, field positions,
 * reset values and load/store access-size encodings.
 * Assumes inclusion by bare name from any design or bench file.
 */
`ifndef FETCH_DISPATCH_MAP_SVH
`define FETCH_DISPATCH_MAP_SVH

`define FD_INSN_W        32
`define FD_SLOTS         8
`define FD_PACKET_W      256
`define FD_CHAIN_BIT     0
`define FD_UNIT_LSB      1
`define FD_UNIT_W        3
`define FD_LS_FLAG_BIT   31
`define FD_SIZE_LSB      4
`define FD_SIZE_W        2
`define FD_SIZE_BYTE     2'h0
`define FD_SIZE_HALF     2'h1
`define FD_SIZE_WORD     2'h2
`define FD_ADDR_RST      32'h00000000
`define FD_SIDE_UNITS    4

`endif

// File: shared/fetch_dispatch_pkg.sv
/*
 * Types shared by the fetch packet dispatcher and its packet holder.
 * Assumes the map header supplies all widths.
 */
`include "fetch_dispatch_map.svh"

package fetch_dispatch_pkg;
    typedef logic [`FD_INSN_W-1:0]   insn_t;
    typedef logic [`FD_PACKET_W-1:0] packet_t;
    typedef logic [`FD_SLOTS-1:0]    slot_mask_t;
    typedef enum logic [1:0] {
        ST_FETCH,
        ST_WAIT,
        ST_ISSUE
    } disp_state_e;
endpackage

// File: shared/packet_hold_if.sv
/*
 * Carrier between the dispatcher and its fetch packet holder.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/10ps
`include "fetch_dispatch_map.svh"

interface packet_hold_if;
    logic                          load;
    fetch_dispatch_pkg::packet_t   wr_packet;
    fetch_dispatch_pkg::packet_t   rd_packet;

    modport holder (
        input  load,
        input  wr_packet,
        output rd_packet
    );
    modport user (
        output load,
        output wr_packet,
        input  rd_packet
    );
endinterface

// File: verification/dispatcher_properties.sv
/* Port checker for the fetch packet dispatcher.
   Assumes it is bound onto the dispatcher top module. */
`timescale 1ns/10ps
`include "fetch_dispatch_map.svh"

module dispatcher_properties #(
    parameter int SLOTS  = `FD_SLOTS,
    parameter int INSN_W = `FD_INSN_W
) (
    input wire logic                    i_clk,
    input wire logic                    i_srst,
    input wire logic                    i_pm_valid,
    input wire logic                    o_pm_req,
    input wire logic [31:0]             o_pm_addr,
    input wire logic [SLOTS-1:0]        o_unit_valid,
    input wire logic [SLOTS*INSN_W-1:0] o_unit_insn,
    input wire logic [SLOTS*2-1:0]      o_unit_size,
    input wire logic [SLOTS-1:0]        o_unit_side_b,
    input wire logic                    o_packet_last
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    // Fetch request shape and address hold
    property p_req_pulse; o_pm_req |=> !o_pm_req; endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("request too long");
    property p_addr_hold; o_pm_req |=> $stable(o_pm_addr) [*2]; endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
    // No fetch before the fetch packet is used up
    property p_no_mid_req; (o_unit_valid != 0) && !o_packet_last |=> !o_pm_req; endproperty
    a_no_mid_req: assert property (p_no_mid_req) else $error("early fetch");
    // Request may follow the last execute packet one cycle later, never with it
    property p_gap; o_packet_last |-> !o_pm_req; endproperty
    a_gap: assert property (p_gap) else $error("fetch too soon");
    // Issue timing, one execute packet per clock
    property p_first; i_pm_valid |-> ##2 (o_unit_valid != 0); endproperty
    a_first: assert property (p_first) else $error("no first issue");
    property p_next; (o_unit_valid != 0) && !o_packet_last |=> (o_unit_valid != 0); endproperty
    a_next: assert property (p_next) else $error("issue gap");
    property p_last; o_packet_last |-> (o_unit_valid != 0); endproperty
    a_last: assert property (p_last) else $error("empty last");
    // Side of the issued slots and access size of unit 0
    property p_side; (o_unit_side_b & o_unit_valid) == (o_unit_valid & 8'hF0); endproperty
    a_side: assert property (p_side) else $error("side wrong");
    property p_size; o_unit_valid[0] |-> o_unit_size[1:0] ==
        (o_unit_insn[31] ? o_unit_insn[5:4] : 2'h2); endproperty
    a_size: assert property (p_size) else $error("size wrong");
endmodule

bind vliw_fetch_packet_dispatcher dispatcher_properties #(.SLOTS(SLOTS), .INSN_W(INSN_W)) chk (
    .i_clk(i_clk), .i_srst(i_srst), .i_pm_valid(i_pm_valid), .o_pm_req(o_pm_req),
    .o_pm_addr(o_pm_addr), .o_unit_valid(o_unit_valid), .o_unit_insn(o_unit_insn),
    .o_unit_size(o_unit_size), .o_unit_side_b(o_unit_side_b), .o_packet_last(o_packet_last));

// File: verification/prog_mem_model.sv
/* Program memory model: one valid pulse per fetch request.
   Assumes the bench fills mem before each request. */
`timescale 1ns/10ps

module prog_mem_model (
    input  wire logic         i_clk,
    input  wire logic         i_req,
    input  wire logic [31:0]  i_addr,
    input  wire logic [7:0]   i_lat,
    output logic              o_valid,
    output logic [255:0]      o_packet
);
    logic [255:0] mem [0:3];

    // Whole packet after the set latency, then scrambled data
    initial o_valid = 1'h0;
    initial o_packet = '0;
    always @(posedge i_clk) begin
        if (i_req === 1'h1) begin
            repeat (i_lat) @(posedge i_clk);
            #1;
            o_valid = 1'h1;
            o_packet = mem[i_addr[6:5]];
            @(posedge i_clk);
            #1;
            o_valid = 1'h0;
            o_packet = ~o_packet;
        end
    end
endmodule

// File: verification/test_vliw_fetch_packet_dispatcher.sv
/* Bench for the fetch packet dispatcher.
   Assumes the program memory model answers each request. */
`timescale 1ns/10ps

module test_vliw_fetch_packet_dispatcher;
    logic         i_clk = 1'h0;
    logic         i_srst = 1'h1;
    logic         i_run = 1'h0;
    logic [7:0]   lat = 8'h00;
    logic         pm_valid, pm_req, last;
    logic [255:0] pm_packet, u_insn;
    logic [31:0]  pm_addr;
    logic [7:0]   u_valid, side_b;
    logic [15:0]  u_size;
    int           failures = 0;
    int           tests_run = 0;

    always #25 i_clk = ~i_clk;

    vliw_fetch_packet_dispatcher dut (.i_clk(i_clk), .i_srst(i_srst), .i_run(i_run),
        .i_start_addr(32'h00000000), .i_pm_valid(pm_valid), .i_pm_packet(pm_packet),
        .o_pm_req(pm_req), .o_pm_addr(pm_addr), .o_unit_valid(u_valid), .o_unit_insn(u_insn),
        .o_unit_size(u_size), .o_unit_side_b(side_b), .o_packet_last(last));
    prog_mem_model pm (.i_clk(i_clk), .i_req(pm_req), .i_addr(pm_addr), .i_lat(lat),
        .o_valid(pm_valid), .o_packet(pm_packet));

    task automatic tick;
        @(posedge i_clk);
        #1;
    endtask

    task automatic check(input logic [255:0] seen, input logic [255:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask

    // Packet n: chain bits per slot, units reversed and odd slots loads/stores if rev
    task automatic run_packet(input int n, input logic [7:0] chain, input bit rev);
        logic [255:0] p;
        logic [31:0]  w;
        logic [7:0]   m;
        logic [2:0]   u;
        int           s;
        int           i;
        for (int k = 0; k < 8; k++) begin
            u = rev ? 3'(7 - k) : 3'(k);
            p[32*k +: 32] = {rev & k[0], 25'(k + 1), 2'(k % 3), u, chain[k]};
        end
        pm.mem[n] = p;
        lat = 8'(n);
        for (i = 0; i < 100 && pm_req !== 1'h1; i++) tick;
        check(256'(pm_addr), 256'(32 * n));
        for (i = 0; i < 100 && u_valid === 8'h00; i++) tick;
        s = 0;
        while (s < 8) begin
            m = 8'h00;
            do begin
                w = p[32*s +: 32];
                u = w[3:1];
                m[u] = 1'h1;
                check(256'(u_insn[32*u +: 32]), 256'(w));
                check(256'(u_size[2*u +: 2]), 256'(w[31] ? w[5:4] : 2'h2));
                check(256'(side_b[u]), 256'(u[2]));
                s++;
            end while (w[0] && s < 8);
            check(256'(u_valid), 256'(m));
            check(256'(last), 256'(s == 8));
            tick;
        end
        $display("packet test %0d done", n);
    endtask

    task automatic close_out;
        $display("checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Reset, load start address, then four fetch packets
    initial begin
        repeat (10) @(posedge i_clk);
        #1;
        i_srst = 1'h0;
        tick;
        i_run = 1'h1;
        run_packet(0, 8'h7F, 1'b0);
        run_packet(1, 8'h00, 1'b0);
        run_packet(2, 8'h49, 1'b1);
        run_packet(3, 8'h3F, 1'b1);
        i_run = 1'h0;
        close_out;
    end

    // Hang guard
    initial begin
        repeat (600) @(posedge i_clk);
        failures++;
        close_out;
    end
endmodule
